// ---- hw/pamx_pad.sv ----
// One port pad cell: output mux, drive mode, pull-up and input gating.
// Assumes pin input already synchronous to clk_sys.
`timescale 1ns/10ps
module pamx_pad
  import pamx_pkg::*;
#(
  parameter bit OPEN_DRAIN = 1'b0
) (
  // Configuration
  input wire logic dataBit,
  input wire logic dirOut,
  input wire logic pullEn,
  input wire logic digInEn,
  input wire logic analogSel,
  input wire pamx_sel_type funcSel,
  input wire logic alt1Out,
  input wire logic alt2Out,
  // Pad
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  output logic padPullUp,
  output logic digIn
);
  logic drvVal;
  logic altActive;

  always_comb begin
    altActive = (funcSel == PAMX_SEL_ALT1) || (funcSel == PAMX_SEL_ALT2);
    // Alternate output wins over the port data bit [R12]
    case (funcSel)
      PAMX_SEL_ALT1: drvVal = alt1Out;
      PAMX_SEL_ALT2: drvVal = alt2Out;
      default: drvVal = dataBit;
    endcase
    if (analogSel) begin
      padOe = 1'b0;
      padOut = 1'b0;
    end else if (OPEN_DRAIN) begin
      // Only ever pulls low; high comes from the pull-up [R2]
      padOe = (dirOut || altActive) && !drvVal;
      padOut = 1'b0;
    end else begin
      // Push-pull drive [R1]
      padOe = dirOut || altActive;
      padOut = drvVal;
    end
    padPullUp = pullEn && !analogSel && !padOe;
    // Input buffer blocked when digital input disabled [R10]
    digIn = digInEn && padIn;
  end
endmodule

// ---- hw/pamx_port_upper.sv ----
// Port A upper pins (bits 3..7): GPIO, crystal, alternates, ext int line one, wake.
// Assumes an Avalon-MM master on clk_sys and pad inputs synchronous to clk_sys.
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
`include "pamx_cfg.svh"

// Functional notes
// R1: Bits 3, 4, 6 and 7 are digital input or push-pull output with optional pull-up.
// R2: Bit 5 is digital input or open-drain output with optional pull-up and never drives high.
// R3: Bit 5 cannot wake the device while its digital input enable is zero.
// R4: With the crystal selected, bit 7 is the crystal input terminal.
// R5: With the crystal selected, bit 6 is the crystal output terminal.
// R6: Software using the crystal must clear the input enables of bits 6 and 7.
// R7: Bit 4 also serves as ADC channel nine, comparator plus, comparator minus one, ext int one, PWM gen one.
// R8: The external interrupt line requests on rising and/or falling edges chosen by register.
// R9: Bit 3 also serves as ADC channel eight, comparator minus zero, timer two PWM, PWM gen two.
// R10: A cleared input enable blocks the input buffer and stops that pin waking the device.
// R11: With input enabled, a toggling pin during sleep wakes the system.
// R12: A selected alternate output overrides the port data bit on its pin.
module pamx_port_upper
  import pamx_pkg::*;
#(
  parameter int NPIN = 5
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  // Avalon-MM slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // Pads, index 0 is port bit 3
  input wire logic [NPIN-1:0] padIn,
  output logic [NPIN-1:0] padOut,
  output logic [NPIN-1:0] padOe,
  output logic [NPIN-1:0] padPullUp,
  // Analog and alternate functions
  input wire logic pwm_generator_one_output,
  input wire logic pwm_generator_two_output,
  input wire logic timer_two_pwm_output,
  input wire logic crystal_out_pin,
  output logic crystal_in_pin,
  output logic adc_channel_eight,
  output logic adc_channel_nine,
  output logic comparator_plus_input,
  output logic comparator_minus_source_zero,
  output logic comparator_minus_source_one,
  output logic external_interrupt_line_one,
  output logic hardware_reset_pin,
  // Events
  output logic wakeReq,
  output logic irq
);
  localparam int B3 = 0;
  localparam int B4 = 1;
  localparam int B5 = 2;
  localparam int B6 = 3;
  localparam int B7 = 4;

  // ==========================================================
  // Registers
  logic [NPIN-1:0] dataReg, dataNext, dirReg, dirNext, pullReg, pullNext, dienReg, dienNext;
  logic [2*NPIN-1:0] funcReg, funcNext;
  logic [3:0] ctrlReg, ctrlNext;
  logic [1:0] statReg, statNext, maskReg, maskNext;
  logic [NPIN-1:0] inPrevReg, inPrevNext;
  logic [31:0] rdReg, rdNext;
  pamx_bus_type busReg, busNext;
  logic [NPIN-1:0] digIn;
  logic [NPIN-1:0] analogSel;
  logic xtalOn, evRise, evFall, extEvent, toggleWake;

  function automatic pamx_sel_type selOf(input logic [2*NPIN-1:0] f, input int idx);
    return pamx_sel_type'(f[2*idx +: 2]);
  endfunction

  function automatic logic hitOfs(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  // ==========================================================
  // Pad cells
  assign xtalOn = ctrlReg[`PAMX_CTRL_XTAL];
  always_comb begin
    analogSel = '0;
    // Crystal takes over bits 6 and 7 [R4] [R5]
    analogSel[B6] = xtalOn;
    analogSel[B7] = xtalOn;
  end

  // Push-pull pads on bits 3, 4, 6 and 7 [R1]
  pamx_pad #(.OPEN_DRAIN(1'b0)) uPad3 (
    .dataBit(dataReg[B3]),
    .dirOut(dirReg[B3]),
    .pullEn(pullReg[B3]),
    .digInEn(dienReg[B3]),
    .analogSel(analogSel[B3]),
    .funcSel(selOf(funcReg, B3)),
    .alt1Out(timer_two_pwm_output), // [R9] [R12]
    .alt2Out(pwm_generator_two_output), // [R9] [R12]
    .padIn(padIn[B3]),
    .padOut(padOut[B3]),
    .padOe(padOe[B3]),
    .padPullUp(padPullUp[B3]),
    .digIn(digIn[B3])
  );
  pamx_pad #(.OPEN_DRAIN(1'b0)) uPad4 (
    .dataBit(dataReg[B4]),
    .dirOut(dirReg[B4]),
    .pullEn(pullReg[B4]),
    .digInEn(dienReg[B4]),
    .analogSel(analogSel[B4]),
    .funcSel(selOf(funcReg, B4)),
    .alt1Out(pwm_generator_one_output), // [R7] [R12]
    .alt2Out(pwm_generator_one_output), // [R7] [R12]
    .padIn(padIn[B4]),
    .padOut(padOut[B4]),
    .padOe(padOe[B4]),
    .padPullUp(padPullUp[B4]),
    .digIn(digIn[B4])
  );
  // Open-drain pad on bit 5; its PWM output can only pull low [R2]
  pamx_pad #(.OPEN_DRAIN(1'b1)) uPad5 (
    .dataBit(dataReg[B5]),
    .dirOut(dirReg[B5]),
    .pullEn(pullReg[B5]),
    .digInEn(dienReg[B5]),
    .analogSel(analogSel[B5]),
    .funcSel(selOf(funcReg, B5)),
    .alt1Out(pwm_generator_two_output), // [R2] [R12]
    .alt2Out(pwm_generator_two_output), // [R2] [R12]
    .padIn(padIn[B5]),
    .padOut(padOut[B5]),
    .padOe(padOe[B5]),
    .padPullUp(padPullUp[B5]),
    .digIn(digIn[B5])
  );
  // No alternate output on bits 6 and 7; both selections fall back to the data bit [R1]
  pamx_pad #(.OPEN_DRAIN(1'b0)) uPad6 (
    .dataBit(dataReg[B6]),
    .dirOut(dirReg[B6]),
    .pullEn(pullReg[B6]),
    .digInEn(dienReg[B6]),
    .analogSel(analogSel[B6]),
    .funcSel(selOf(funcReg, B6)),
    .alt1Out(dataReg[B6]),
    .alt2Out(dataReg[B6]),
    .padIn(padIn[B6]),
    .padOut(padOut[B6]),
    .padOe(padOe[B6]),
    .padPullUp(padPullUp[B6]),
    .digIn(digIn[B6])
  );
  pamx_pad #(.OPEN_DRAIN(1'b0)) uPad7 (
    .dataBit(dataReg[B7]),
    .dirOut(dirReg[B7]),
    .pullEn(pullReg[B7]),
    .digInEn(dienReg[B7]),
    .analogSel(analogSel[B7]),
    .funcSel(selOf(funcReg, B7)),
    .alt1Out(dataReg[B7]),
    .alt2Out(dataReg[B7]),
    .padIn(padIn[B7]),
    .padOut(padOut[B7]),
    .padOe(padOe[B7]),
    .padPullUp(padPullUp[B7]),
    .digIn(digIn[B7])
  );

  // ==========================================================
  // Analog and alternate inputs
  // Analog taps are the raw pad levels; the oscillator model lives outside
  always_comb begin
    crystal_in_pin = xtalOn && padIn[B7]; // [R4]
    adc_channel_nine = padIn[B4]; // [R7]
    comparator_plus_input = padIn[B4]; // [R7]
    comparator_minus_source_one = padIn[B4]; // [R7]
    external_interrupt_line_one = digIn[B4]; // [R7]
    adc_channel_eight = padIn[B3]; // [R9]
    comparator_minus_source_zero = padIn[B3]; // [R9]
    hardware_reset_pin = !digIn[B5] && dienReg[B5];
  end
  // Crystal output drive is the oscillator's, not the port's; pad 6 is released [R5]
  logic unusedXtalOut;
  assign unusedXtalOut = crystal_out_pin;

  // ==========================================================
  // Edge and wake detection
  always_comb begin
    inPrevNext = digIn;
    evRise = digIn[B4] && !inPrevReg[B4];
    evFall = !digIn[B4] && inPrevReg[B4];
    // Edge choice from control register [R8]
    extEvent = (evRise && ctrlReg[`PAMX_CTRL_ERISE]) || (evFall && ctrlReg[`PAMX_CTRL_EFALL]);
    // Disabled inputs are gated to zero so they cannot toggle [R3] [R10]
    toggleWake = |((digIn ^ inPrevReg) & dienReg);
    wakeReq = ctrlReg[`PAMX_CTRL_SLEEP] && toggleWake; // [R11]
  end

  // ==========================================================
  // Avalon-MM slave: one wait state on every access
  logic acc, rdStat, wrGo;
  always_comb begin
    acc = (avsRead || avsWrite) && (busReg == PAMX_BUS_IDLE);
    // Writes land on the edge where the master sees waitrequest low; a frozen clock keeps the wait
    wrGo = avsWrite && (busReg == PAMX_BUS_DONE);
    avsWaitRequest = (avsRead || avsWrite) && ((busReg == PAMX_BUS_IDLE) || !clkEn);
    rdStat = acc && avsRead && hitOfs(avsAddress, `PAMX_OFS_STAT);
    busNext = acc ? PAMX_BUS_DONE : PAMX_BUS_IDLE;
    dataNext = dataReg;
    dirNext = dirReg;
    pullNext = pullReg;
    dienNext = dienReg;
    funcNext = funcReg;
    ctrlNext = ctrlReg;
    maskNext = maskReg;
    rdNext = rdReg;
    if (wrGo && avsByteEnable[0]) begin
      case (avsAddress)
        `PAMX_OFS_DATA: dataNext = avsWriteData[NPIN-1:0];
        `PAMX_OFS_DIR: dirNext = avsWriteData[NPIN-1:0];
        `PAMX_OFS_PULL: pullNext = avsWriteData[NPIN-1:0];
        `PAMX_OFS_DIEN: dienNext = avsWriteData[NPIN-1:0];
        `PAMX_OFS_CTRL: ctrlNext = avsWriteData[3:0];
        `PAMX_OFS_MASK: maskNext = avsWriteData[1:0];
        default: ;
      endcase
    end
    if (wrGo && hitOfs(avsAddress, `PAMX_OFS_FUNC)) begin
      if (avsByteEnable[0]) funcNext[7:0] = avsWriteData[7:0];
      if (avsByteEnable[1]) funcNext[9:8] = avsWriteData[9:8];
    end
    if (acc && avsRead) begin
      case (avsAddress)
        `PAMX_OFS_DATA: rdNext = {27'h0, dataReg};
        `PAMX_OFS_DIR: rdNext = {27'h0, dirReg};
        `PAMX_OFS_PULL: rdNext = {27'h0, pullReg};
        `PAMX_OFS_DIEN: rdNext = {27'h0, dienReg};
        `PAMX_OFS_FUNC: rdNext = {22'h0, funcReg};
        `PAMX_OFS_CTRL: rdNext = {28'h0, ctrlReg};
        `PAMX_OFS_STAT: rdNext = {30'h0, statReg};
        `PAMX_OFS_MASK: rdNext = {30'h0, maskReg};
        `PAMX_OFS_PIN: rdNext = {27'h0, digIn};
        default: rdNext = 32'h0;
      endcase
    end
    // Read clears status; a new event in the same cycle survives
    statNext = rdStat ? 2'h0 : statReg;
    if (extEvent) statNext[`PAMX_STAT_EXTINT] = 1'b1; // [R8]
    if (wakeReq) statNext[`PAMX_STAT_WAKE] = 1'b1; // [R11]
    irq = |(statReg & maskReg);
    avsReadData = rdReg;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dataReg <= `PAMX_RST_DATA;
      dirReg <= `PAMX_RST_DIR;
      pullReg <= `PAMX_RST_PULL;
      dienReg <= `PAMX_RST_DIEN;
      funcReg <= `PAMX_RST_FUNC;
      ctrlReg <= `PAMX_RST_CTRL;
      maskReg <= `PAMX_RST_MASK;
      statReg <= 2'h0;
      inPrevReg <= '0;
      rdReg <= 32'h0;
      busReg <= PAMX_BUS_IDLE;
    end else if (clkEn) begin
      dataReg <= dataNext;
      dirReg <= dirNext;
      pullReg <= pullNext;
      dienReg <= dienNext;
      funcReg <= funcNext;
      ctrlReg <= ctrlNext;
      maskReg <= maskNext;
      statReg <= statNext;
      inPrevReg <= inPrevNext;
      rdReg <= rdNext;
      busReg <= busNext;
    end
  end

  // ==========================================================
  // Assertions
  AST_PA5_NEVER_HIGH: assert property (@(posedge clk_sys) disable iff (!nrst) padOe[B5] |-> !padOut[B5]) // [R2]
    else $error("bit 5 drove high");
  AST_XTAL_RELEASE: assert property (@(posedge clk_sys) disable iff (!nrst) // [R4]
    ctrlReg[`PAMX_CTRL_XTAL] |-> (padOe[B7] == 1'b0) && (padOe[B6] == 1'b0))
    else $error("crystal pins driven by port");
  AST_PA5_NO_WAKE: assert property (@(posedge clk_sys) disable iff (!nrst) // [R3]
    (!dienReg[B5] && (digIn[B3] == inPrevReg[B3]) && (digIn[B4] == inPrevReg[B4])
      && (digIn[B6] == inPrevReg[B6]) && (digIn[B7] == inPrevReg[B7])) |-> !wakeReq)
    else $error("disabled bit 5 woke device");
  AST_WAKE_TOGGLE: assert property (@(posedge clk_sys) disable iff (!nrst) // [R11]
    (clkEn && ctrlReg[`PAMX_CTRL_SLEEP] && dienReg[B3] && (digIn[B3] != inPrevReg[B3])) |-> wakeReq)
    else $error("toggle during sleep missed");
  AST_EXT_RISE: assert property (@(posedge clk_sys) disable iff (!nrst) // [R8]
    (clkEn && ctrlReg[`PAMX_CTRL_ERISE] && digIn[B4] && !inPrevReg[B4]) |=> statReg[`PAMX_STAT_EXTINT])
    else $error("rising edge not latched");
  AST_EXT_NOEDGE: assert property (@(posedge clk_sys) disable iff (!nrst) // [R8]
    (clkEn && !ctrlReg[`PAMX_CTRL_ERISE] && !ctrlReg[`PAMX_CTRL_EFALL]) |-> !extEvent)
    else $error("edge event with both edges off");
  AST_DIN_BLOCK: assert property (@(posedge clk_sys) disable iff (!nrst) !dienReg[B4] |-> !external_interrupt_line_one) // [R10]
    else $error("disabled input passed");
  AST_ALT_OVERRIDE: assert property (@(posedge clk_sys) disable iff (!nrst) // [R12]
    (funcReg[3:2] == 2'b01 && !analogSel[B4]) |-> padOe[B4] && (padOut[B4] == pwm_generator_one_output))
    else $error("alternate output not on pin");
  AST_PUSH_PULL: assert property (@(posedge clk_sys) disable iff (!nrst) // [R1]
    (dirReg[B3] && funcReg[1:0] == 2'b00) |-> padOe[B3] && (padOut[B3] == dataReg[B3]))
    else $error("push-pull data mismatch");
  AST_IRQ_MASK: assert property (@(posedge clk_sys) disable iff (!nrst) irq == |(statReg & maskReg))
    else $error("irq mismatch");
endmodule

// ---- pkg/pamx_cfg.svh ----
// Register offsets, field positions, reset values for the port A upper pin mux.
// Assumes inclusion by bare name from any design file that needs it.
`ifndef PAMX_CFG_SVH
`define PAMX_CFG_SVH
// Register word offsets (consecutive addresses, one per register)
`define PAMX_OFS_DATA 4'h0
`define PAMX_OFS_DIR 4'h1
`define PAMX_OFS_PULL 4'h2
`define PAMX_OFS_DIEN 4'h3
`define PAMX_OFS_FUNC 4'h4
`define PAMX_OFS_CTRL 4'h5
`define PAMX_OFS_STAT 4'h6
`define PAMX_OFS_MASK 4'h7
`define PAMX_OFS_PIN 4'h8
// Field positions
`define PAMX_CTRL_XTAL 0
`define PAMX_CTRL_SLEEP 1
`define PAMX_CTRL_ERISE 2
`define PAMX_CTRL_EFALL 3
`define PAMX_STAT_EXTINT 0
`define PAMX_STAT_WAKE 1
// Reset values
`define PAMX_RST_DATA 5'h00
`define PAMX_RST_DIR 5'h00
`define PAMX_RST_PULL 5'h00
`define PAMX_RST_DIEN 5'h1f
`define PAMX_RST_FUNC 10'h000
`define PAMX_RST_CTRL 4'h0
`define PAMX_RST_MASK 2'h0
`endif

// ---- pkg/pamx_pkg.sv ----
// Types shared by the port A upper pin mux design files.
// Assumes nothing beyond a SystemVerilog compiler.
package pamx_pkg;
  // Per-pin alternate output selection
  typedef enum logic [1:0] {
    PAMX_SEL_GPIO = 2'b00,
    PAMX_SEL_ALT1 = 2'b01,
    PAMX_SEL_ALT2 = 2'b10,
    PAMX_SEL_RSVD = 2'b11
  } pamx_sel_type;
  // Bus slave states
  typedef enum logic [0:0] {
    PAMX_BUS_IDLE = 1'b0,
    PAMX_BUS_DONE = 1'b1
  } pamx_bus_type;
endpackage

// ---- tb/pamx_board.sv ----
// Board model for the upper port pins: resolves each pin from pad drive, a bench source and pull-up.
// Assumes pad signals of the port block and a bench source that is sampled on clk_sys.
`timescale 1ns/10ps
module pamx_board (
  // Clock
  input wire logic clk_sys,
  // Pad side
  input wire logic [4:0] padOut,
  input wire logic [4:0] padOe,
  input wire logic [4:0] padPullUp,
  output logic [4:0] padIn,
  // Bench source
  input wire logic [4:0] extEn,
  input wire logic [4:0] extVal
);
  // ==========================================
  // Pin resolution
  // A floating pin wanders every cycle so a stale level never passes for a real one
  logic [4:0] floatReg = 5'h0a;
  always_ff @(posedge clk_sys) begin
    floatReg <= ~floatReg;
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      padIn[i] = padOe[i] ? padOut[i] : extEn[i] ? extVal[i] : padPullUp[i] ? 1'b1 : floatReg[i];
    end
  end
endmodule

// ---- tb/tb.sv ----
// Bench for the port A upper pin mux: register bus tasks and one task per scenario.
// Assumes the board model and the design package and header on the include path.
`timescale 1ns/10ps
`include "pamx_cfg.svh"
module tb;
  import pamx_pkg::*;
  // ==========================================
  // Signals
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData, rd;
  logic avsWaitRequest, xIn, ad8, ad9, cPl, cM0, cM1, eLn, wakeReq, irq, hwRst;
  logic [4:0] padIn, padOut, padOe, padPullUp;
  logic [4:0] extEn = 5'h1f;
  logic [4:0] extVal = 5'h0a;
  logic pg1 = 1'b0;
  logic pg2 = 1'b0;
  logic tm2 = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  pamx_port_upper #(.NPIN(5)) u_pamx_port_upper (.clk_sys(clk_sys), .nrst(nrst), .clkEn(1'b1),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'hf), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp), .pwm_generator_one_output(pg1),
    .pwm_generator_two_output(pg2), .timer_two_pwm_output(tm2), .crystal_out_pin(1'b0),
    .crystal_in_pin(xIn), .adc_channel_eight(ad8), .adc_channel_nine(ad9), .comparator_plus_input(cPl),
    .comparator_minus_source_zero(cM0), .comparator_minus_source_one(cM1),
    .external_interrupt_line_one(eLn), .hardware_reset_pin(hwRst), .wakeReq(wakeReq), .irq(irq));
  pamx_board u_pamx_board (.clk_sys(clk_sys), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp),
    .padIn(padIn), .extEn(extEn), .extVal(extVal));
  // ==========================================
  // Shared tasks
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    avsAddress <= adr;
    avsWriteData <= wd;
    avsWrite <= wr;
    avsRead <= !wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (n >= 50) begin
      $display("BAD bus answer expected waitrequest low seen high");
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic drive(input logic [4:0] en, input logic [4:0] val);
    @(posedge clk_sys);
    extEn <= en;
    extVal <= val;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    check("padOe", padOe, 32'h0);
    check("irq", irq, 32'h0);
    bus(1'b0, `PAMX_OFS_DIEN, 32'h0);
    check("dien", rd, 32'h1f);
    bus(1'b1, 4'hd, 32'hff);
    bus(1'b0, 4'hd, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b0, `PAMX_OFS_PIN, 32'h0);
    check("pin", rd, 32'h0a);
    $display("test reset done");
  endtask
  task automatic t_gpio();
    drive(5'h00, 5'h00);
    bus(1'b1, `PAMX_OFS_DIR, 32'h1f);
    bus(1'b1, `PAMX_OFS_DATA, 32'h1f);
    settle();
    check("oe high", padOe, 32'h1b);
    check("out high", padOut & padOe, 32'h1b);
    bus(1'b1, `PAMX_OFS_DATA, 32'h0);
    settle();
    check("oe low", padOe, 32'h1f);
    check("out low", padOut, 32'h0);
    bus(1'b1, `PAMX_OFS_PULL, 32'h15);
    settle();
    check("pull drive", padPullUp, 32'h0);
    bus(1'b1, `PAMX_OFS_DIR, 32'h0);
    settle();
    check("pull", padPullUp, 32'h15);
    bus(1'b1, `PAMX_OFS_PULL, 32'h0);
    $display("test gpio done");
  endtask
  task automatic t_xtal();
    bus(1'b1, `PAMX_OFS_DIEN, 32'h07);
    bus(1'b1, `PAMX_OFS_CTRL, 32'h1 << `PAMX_CTRL_XTAL);
    for (int v = 0; v < 2; v++) begin
      drive(5'h18, {v[0], 4'h0});
      settle();
      check("xtal oe", padOe[4:3], 32'h0);
      check("xtal in", xIn, v[0]);
    end
    bus(1'b1, `PAMX_OFS_CTRL, 32'h0);
    drive(5'h1f, 5'h00);
    bus(1'b1, `PAMX_OFS_DIR, 32'h0);
    bus(1'b1, `PAMX_OFS_DIEN, 32'h1f);
    $display("test crystal done");
  endtask
  task automatic t_alt();
    drive(5'h1c, 5'h00);
    tm2 <= 1'b1;
    pg1 <= 1'b1;
    bus(1'b1, `PAMX_OFS_FUNC, 32'h005);
    settle();
    check("alt1 oe", padOe[1:0], 32'h3);
    check("alt1 out", padOut[1:0], 32'h3);
    pg1 <= 1'b0;
    pg2 <= 1'b1;
    bus(1'b1, `PAMX_OFS_FUNC, 32'h00a);
    settle();
    check("alt2 out", padOut[1:0], 32'h1);
    bus(1'b1, `PAMX_OFS_FUNC, 32'h0);
    for (int v = 1; v < 3; v++) begin
      drive(5'h1f, v[4:0]);
      settle();
      check("analog", {ad8, cM0, ad9, cPl, cM1}, v[0] ? 32'h18 : 32'h07);
    end
    $display("test alternates done");
  endtask
  task automatic t_edge();
    for (int m = 1; m < 4; m++) begin
      drive(5'h1f, 5'h00);
      bus(1'b1, `PAMX_OFS_MASK, 32'h1);
      bus(1'b1, `PAMX_OFS_CTRL, m << `PAMX_CTRL_ERISE);
      bus(1'b0, `PAMX_OFS_STAT, 32'h0);
      for (int e = 0; e < 2; e++) begin
        drive(5'h1f, e ? 5'h00 : 5'h02);
        settle();
        check("edge irq", irq, m[e]);
        check("line", eLn, !e);
        bus(1'b0, `PAMX_OFS_STAT, 32'h0);
        check("edge stat", rd[0], m[e]);
        settle();
        check("irq clear", irq, 32'h0);
      end
    end
    $display("test edges done");
  endtask
  task automatic t_wake();
    bus(1'b1, `PAMX_OFS_CTRL, 32'h1 << `PAMX_CTRL_SLEEP);
    bus(1'b1, `PAMX_OFS_MASK, 32'h2);
    bus(1'b1, `PAMX_OFS_DIEN, 32'h19);
    bus(1'b0, `PAMX_OFS_STAT, 32'h0);
    drive(5'h1f, 5'h06);
    settle();
    check("gated irq", irq, 32'h0);
    check("gated line", eLn, 32'h0);
    bus(1'b0, `PAMX_OFS_PIN, 32'h0);
    check("gated pin", rd, 32'h0);
    check("reset gated", hwRst, 32'h0);
    bus(1'b1, `PAMX_OFS_DIEN, 32'h1f);
    drive(5'h1f, 5'h03);
    settle();
    check("wake irq", irq, 32'h1);
    check("wake idle", wakeReq, 32'h0);
    check("reset pin", hwRst, 32'h1);
    bus(1'b0, `PAMX_OFS_STAT, 32'h0);
    check("wake stat", rd[1], 32'h1);
    $display("test wake done");
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_gpio();
    t_xtal();
    t_alt();
    t_edge();
    t_wake();
    give_verdict();
  end
endmodule
